// ### gps_framer_regs.svh
// Purpose: Register offsets, frame layout and timing constants
// Assumes: 32-bit APB, 100 MHz pclk
// Notes:   Byte offsets count from the first MAC byte
`ifndef GPS_FRAMER_REGS_SVH
`define GPS_FRAMER_REGS_SVH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define A_CTRL      8'h00
`define A_SRC_IP    8'h04
`define A_MAC_LO    8'h08
`define A_MAC_HI    8'h0c
`define A_STATUS    8'h10
`define A_US        8'h14
`define CTRL_PTP    0
`define CTRL_GGA    1
`define RST_SRC_IP  32'hc0a8_01c9
`define RST_MAC     48'h0200_0000_0001
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_NS      10
`define US_NS       1000
`define CYC_PER_US  (`US_NS / `CLK_NS)
`define SEC_US      1_000_000
`define NMEA_TMO_US 2_000_000
`define PPS_TOL_US  100
// ------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------
`define OFS_TYPE    10'h00c
`define OFS_IP_CS   10'h018
`define OFS_IP_SRC  10'h01a
`define OFS_IP_DST  10'h01e
`define OFS_UDP     10'h022
`define OFS_UDP_LEN 10'h026
`define OFS_TIME    10'h02a
`define OFS_US      10'h038
`define OFS_NMEA    10'h03c
`define NMEA_LEN    7'h54
`define OFS_FILL    10'h090
`define OFS_STAT    10'h224
`define OFS_PPS     10'h225
`define FRAME_LEN   10'h22a
// ------------------------------------------------------------
// Field values
// ------------------------------------------------------------
`define MAC_BCAST   48'hffff_ffff_ffff
`define ETH_TYPE    16'h0800
`define IP_VH       16'h4500
`define IP_LEN      16'h021c
`define IP_ID       16'h0000
`define IP_FLAGS    16'h4000
`define IP_TTL      8'h40
`define IP_PROTO    8'h11
`define IP_DST      32'hffff_ffff
`define UDP_SRC     16'h2710
`define UDP_DST     16'h277e
`define UDP_LEN     16'h0208
`define UDP_CSUM    16'h0000
`define TIME_MARK   16'hffee
`define FILL_BYTE   8'hdf
`define CH_DOLLAR   8'h24
`define CH_COMMA    8'h2c
`define CH_STAR     8'h2a
`define TYP_RMC     24'h52_4d43
`define TYP_GGA     24'h47_4741
`define F_TIME      4'h1
`define F_STAT      4'h2
`define F_FIX       4'h6
`define F_DATE      4'h9
`endif

// ### gps_framer_pkg.sv
// Purpose: Types shared by the time packet framer
// Assumes: Nothing
// Notes:   Gray codes along the usual state path
package gps_framer_pkg;
   typedef enum logic [1:0] {
      FS_IDLE = 2'b00,
      FS_SEND = 2'b01
   } frm_state_e;
   typedef enum logic [1:0] {
      PS_HUNT = 2'b00,
      PS_BODY = 2'b01,
      PS_SUM1 = 2'b11,
      PS_SUM2 = 2'b10
   } prs_state_e;
   typedef struct packed {
      logic [5:0][7:0] tm;
      logic [5:0][7:0] dt;
      logic [7:0]      st;
   } nmea_fix_s;
   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } tx_beat_s;
endpackage : gps_framer_pkg

// ### sync_2ff.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Single pclk domain
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module sync_2ff #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Data
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : sync_2ff

// ### gps_time_packet_framer.sv
// Purpose: Once-per-second UDP time packet from PPS and NMEA
// Assumes: NMEA bytes arrive from a UART on pclk
// Notes:   Byte stream out, valid/ready, one byte a beat
// Operation
// R01: GPS time source: exactly one time packet per second. The code skips the two packets due after PPS pulses stop while locked.
// R02: PTP time source: no time packets at all.
// R03: Multi-byte payload numbers go least significant byte first.
// R04: IPv4 source address defaults to 192.168.1.201.
// R05: IPv4 destination is 255.255.255.255.
// R06: Header: broadcast MAC, own MAC, type 08 00, 42 bytes.
// R07: UDP ports 0x2710 source, 0x277E destination.
// R08: UDP length field is 0x208.
// R09: Time section: FFEE, date, time, four reserved, units first. The code sends the microsecond count in the four reserved bytes.
// R10: 84 bytes carry the received NMEA sentence.
// R11: RMC status byte: A, V, or zero when unlocked.
// R12: GGA status byte: fix-quality digit from field six.
// R13: PPS lock flag byte: one locked, zero not.
// R14: RMC parser takes time from field one, date field nine.
// R15: GGA parser takes time from field one, fractions allowed.
// R16: Microsecond counter cleared on every PPS rising edge.
// R17: NMEA unlocked after over two seconds without valid sentence.
// R18: PPS lock reports internal clock synchronised to PPS.
// R19: 404 fill bytes 0xDF, status, flag, four reserved bytes.
// R20: Correct IPv4 header checksum; UDP checksum sent as zero.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "gps_framer_regs.svh"
module gps_time_packet_framer #(
   parameter int SEC_US      = `SEC_US,
   parameter int NMEA_TMO_US = `NMEA_TMO_US,
   parameter int PPS_TOL_US  = `PPS_TOL_US
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   // GPS receiver
   input  wire logic        pps_pin,
   input  wire logic        nmea_valid,
   input  wire logic [7:0]  nmea_byte,
   // Ethernet transmit path
   output      logic        tx_valid,
   output      logic [7:0]  tx_data,
   output      logic        tx_last,
   input  wire logic        tx_ready
);
   localparam int CYC = `CYC_PER_US;
   localparam int PW  = $clog2(CYC);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [1:0]   ctrl_q, ctrl_d;
   logic [31:0]  src_ip_q, src_ip_d;
   logic [47:0]  mac_q, mac_d;
   logic [31:0]  prdata_q, prdata_d, rd_val;
   logic         pready_q, pready_d, pslverr_q, pslverr_d;
   logic         map_ok, gga;
   logic         pps_s, pps_d1_q, pps_rise;
   logic [PW-1:0] pre_q, pre_d;
   logic [31:0]  us_q, us_d, nm_cnt_q, nm_cnt_d;
   logic         tick, wrap, sec_tick;
   logic         wrapped_q, wrapped_d, pps_lock_q, pps_lock_d;
   logic         nmea_lock_q, nmea_lock_d;
   gps_framer_pkg::prs_state_e ps_q, ps_d;
   logic [3:0]   fld_q, fld_d, hi_q, hi_d;
   logic [2:0]   pos_q, pos_d;
   logic [6:0]   chr_q, chr_d;
   logic [7:0]   xs_q, xs_d;
   logic         bad_q, bad_d, sen_ok_q, sen_ok_d;
   logic [4:0]   nib;
   logic [23:0]  exp_typ;
   gps_framer_pkg::nmea_fix_s cur_q, cur_d, fix_q, fix_d;
   logic [83:0][7:0] cap_q, cap_d, sen_q, sen_d;
   gps_framer_pkg::frm_state_e fs_q, fs_d;
   gps_framer_pkg::tx_beat_s   tx_q, tx_d;
   logic [9:0]   idx_q, idx_d;
   logic [31:0]  fr_us_q, fr_us_d;
   logic [7:0]   fr_st_q, fr_st_d, cur_byte;
   logic         fr_pps_q, fr_pps_d, start, ld, busy;
   logic [335:0] hdr;
   logic [143:0] tsec;
   logic [47:0]  tail;

   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign tx_valid = tx_q.valid;
   assign tx_last  = tx_q.last;
   assign tx_data  = tx_q.data;
   assign gga      = ctrl_q[`CTRL_GGA];
   assign busy     = (fs_q != gps_framer_pkg::FS_IDLE);

   // ------------------------------------------------------------
   // APB registers
   // ------------------------------------------------------------
   // One wait state so read data leaves a flop
   always_comb begin
      ctrl_d   = ctrl_q;
      src_ip_d = src_ip_q;
      mac_d    = mac_q;
      rd_val   = 32'h0000_0000;
      map_ok   = 1'b1;
      case (paddr)
         `A_CTRL:   rd_val = {30'h0, ctrl_q};
         `A_SRC_IP: rd_val = src_ip_q;
         `A_MAC_LO: rd_val = mac_q[31:0];
         `A_MAC_HI: rd_val = {16'h0000, mac_q[47:32]};
         `A_STATUS: rd_val = {29'h0, busy, pps_lock_q, nmea_lock_q};
         `A_US:     rd_val = us_q;
         default:   map_ok = 1'b0;
      endcase
      pready_d  = psel & penable & ~pready_q;
      prdata_d  = pready_d ? rd_val : prdata_q;
      pslverr_d = pready_d & ~map_ok;
      if (psel && penable && pready_q && pwrite) begin
         case (paddr)
            `A_CTRL:   ctrl_d = pwdata[1:0];
            `A_SRC_IP: src_ip_d = pwdata;
            `A_MAC_LO: mac_d[31:0] = pwdata;
            `A_MAC_HI: mac_d[47:32] = pwdata[15:0];
            default:   ctrl_d = ctrl_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q    <= 2'h0;
         src_ip_q  <= `RST_SRC_IP; // see R04
         mac_q     <= `RST_MAC;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         src_ip_q  <= src_ip_d;
         mac_q     <= mac_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ------------------------------------------------------------
   // Timebase and lock tracking
   // ------------------------------------------------------------
   sync_2ff #(.W(1)) u_pps_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (pps_pin),
      .q       (pps_s)
   );
   assign pps_rise = pps_s & ~pps_d1_q;
   assign tick     = (pre_q == PW'(CYC - 1));
   // Locked: packet follows PPS, else the free-running wrap
   assign sec_tick = pps_lock_q ? pps_rise : wrap; // see R01

   always_comb begin
      pre_d       = tick ? '0 : PW'(pre_q + 1'b1);
      us_d        = us_q;
      wrap        = 1'b0;
      wrapped_d   = wrapped_q;
      pps_lock_d  = pps_lock_q;
      nm_cnt_d    = nm_cnt_q;
      nmea_lock_d = nmea_lock_q;
      if (pps_rise) begin
         pre_d     = '0;
         us_d      = 32'h0000_0000; // see R16
         wrapped_d = 1'b0;
         // Edge one second after the last one means in sync
         pps_lock_d = (us_q < 32'(PPS_TOL_US)) ||
                      (us_q > 32'(SEC_US - 1 - PPS_TOL_US)); // see R18
      end else if (tick) begin
         if (us_q == 32'(SEC_US - 1)) begin
            us_d      = 32'h0000_0000;
            wrap      = 1'b1;
            wrapped_d = 1'b1;
            if (wrapped_q) pps_lock_d = 1'b0; // see R18
         end else begin
            us_d = us_q + 32'h0000_0001;
         end
      end
      if (sen_ok_q) begin
         nm_cnt_d    = 32'h0000_0000;
         nmea_lock_d = 1'b1; // see R17
      end else if (tick) begin
         if (nm_cnt_q >= 32'(NMEA_TMO_US)) nmea_lock_d = 1'b0; // see R17
         else nm_cnt_d = nm_cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pps_d1_q    <= 1'b0;
         pre_q       <= '0;
         us_q        <= 32'h0000_0000;
         wrapped_q   <= 1'b0;
         pps_lock_q  <= 1'b0;
         nm_cnt_q    <= 32'h0000_0000;
         nmea_lock_q <= 1'b0;
      end else begin
         pps_d1_q    <= pps_s;
         pre_q       <= pre_d;
         us_q        <= us_d;
         wrapped_q   <= wrapped_d;
         pps_lock_q  <= pps_lock_d;
         nm_cnt_q    <= nm_cnt_d;
         nmea_lock_q <= nmea_lock_d;
      end
   end

   // ------------------------------------------------------------
   // NMEA parser
   // ------------------------------------------------------------
   function automatic logic [4:0] hex_nib(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) return {1'b0, c[3:0]};
      if (c >= 8'h41 && c <= 8'h46) return {1'b0, 4'(c[3:0] + 4'h9)};
      return 5'h10;
   endfunction : hex_nib

   // Talker not checked; only the three type letters
   always_comb begin
      ps_d     = ps_q;
      fld_d    = fld_q;
      pos_d    = pos_q;
      chr_d    = chr_q;
      xs_d     = xs_q;
      hi_d     = hi_q;
      bad_d    = bad_q;
      cur_d    = cur_q;
      cap_d    = cap_q;
      sen_ok_d = 1'b0;
      nib      = hex_nib(nmea_byte);
      exp_typ  = gga ? `TYP_GGA : `TYP_RMC;
      fix_d    = fix_q;
      sen_d    = sen_q;
      // Snapshot frozen while a frame is out
      if (sen_ok_q && !busy) begin
         fix_d = cur_q;
         sen_d = cap_q; // see R10
      end
      if (nmea_valid && nmea_byte == `CH_DOLLAR) begin
         ps_d     = gps_framer_pkg::PS_BODY;
         fld_d    = 4'h0;
         pos_d    = 3'h0;
         chr_d    = 7'h01;
         xs_d     = 8'h00;
         bad_d    = 1'b0;
         cur_d    = '0;
         cap_d    = '0;
         cap_d[0] = nmea_byte;
      end else if (nmea_valid) begin
         if (chr_q < `NMEA_LEN && ps_q != gps_framer_pkg::PS_HUNT) begin
            cap_d[chr_q] = nmea_byte; // see R10
            chr_d        = chr_q + 7'h01;
         end
         case (ps_q)
            gps_framer_pkg::PS_BODY: begin
               if (nmea_byte == `CH_STAR) begin
                  ps_d = gps_framer_pkg::PS_SUM1;
               end else if (nmea_byte == `CH_COMMA) begin
                  xs_d  = xs_q ^ nmea_byte;
                  fld_d = (fld_q == 4'hf) ? fld_q : fld_q + 4'h1;
                  pos_d = 3'h0;
               end else begin
                  xs_d  = xs_q ^ nmea_byte;
                  pos_d = (pos_q == 3'h7) ? pos_q : pos_q + 3'h1;
                  if (fld_q == 4'h0 && pos_q >= 3'h2 && pos_q <= 3'h4 &&
                      nmea_byte != exp_typ[8*(4-int'(pos_q)) +: 8])
                     bad_d = 1'b1;
                  // Fraction digits fall past position five
                  if (fld_q == `F_TIME && pos_q < 3'h6)
                     cur_d.tm[pos_q] = nmea_byte; // see R14 see R15
                  if (!gga && fld_q == `F_STAT && pos_q == 3'h0)
                     cur_d.st = nmea_byte; // see R11
                  if (!gga && fld_q == `F_DATE && pos_q < 3'h6)
                     cur_d.dt[pos_q] = nmea_byte; // see R14
                  if (gga && fld_q == `F_FIX && pos_q == 3'h0)
                     cur_d.st = nmea_byte; // see R12
               end
            end
            gps_framer_pkg::PS_SUM1: begin
               hi_d  = nib[3:0];
               bad_d = bad_q | nib[4];
               ps_d  = gps_framer_pkg::PS_SUM2;
            end
            gps_framer_pkg::PS_SUM2: begin
               ps_d     = gps_framer_pkg::PS_HUNT;
               sen_ok_d = !bad_q && !nib[4] && {hi_q, nib[3:0]} == xs_q;
            end
            default: ps_d = gps_framer_pkg::PS_HUNT;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ps_q     <= gps_framer_pkg::PS_HUNT;
         fld_q    <= 4'h0;
         pos_q    <= 3'h0;
         chr_q    <= 7'h00;
         xs_q     <= 8'h00;
         hi_q     <= 4'h0;
         bad_q    <= 1'b0;
         sen_ok_q <= 1'b0;
         cur_q    <= '0;
         cap_q    <= '0;
         fix_q    <= '0;
         sen_q    <= '0;
      end else begin
         ps_q     <= ps_d;
         fld_q    <= fld_d;
         pos_q    <= pos_d;
         chr_q    <= chr_d;
         xs_q     <= xs_d;
         hi_q     <= hi_d;
         bad_q    <= bad_d;
         sen_ok_q <= sen_ok_d;
         cur_q    <= cur_d;
         cap_q    <= cap_d;
         fix_q    <= fix_d;
         sen_q    <= sen_d;
      end
   end

   // ------------------------------------------------------------
   // Frame builder
   // ------------------------------------------------------------
   function automatic logic [15:0] ip_csum(input logic [31:0] sip);
      logic [19:0] s;
      logic [31:0] d;
      d = `IP_DST;
      s = {4'h0, `IP_VH} + {4'h0, `IP_LEN} + {4'h0, `IP_ID} +
          {4'h0, `IP_FLAGS} + {4'h0, `IP_TTL, `IP_PROTO} +
          {4'h0, sip[31:16]} + {4'h0, sip[15:0]} +
          {4'h0, d[31:16]} + {4'h0, d[15:0]};
      s = {4'h0, s[15:0]} + {16'h0000, s[19:16]};
      s = {4'h0, s[15:0]} + {16'h0000, s[19:16]};
      return ~s[15:0];
   endfunction : ip_csum

   always_comb begin
      hdr = {`MAC_BCAST, mac_q, `ETH_TYPE, // see R06
             `IP_VH, `IP_LEN, `IP_ID, `IP_FLAGS, `IP_TTL, `IP_PROTO,
             ip_csum(src_ip_q), src_ip_q, `IP_DST, // see R05 see R20
             `UDP_SRC, `UDP_DST, `UDP_LEN, `UDP_CSUM}; // see R07 see R08
      // Digits stored tens first; packed order sends units first
      tsec = {`TIME_MARK, fix_q.dt, fix_q.tm, // see R09
              {<<8{fr_us_q}}}; // see R03
      tail = {fr_st_q, 7'h00, fr_pps_q, 32'h0000_0000}; // see R13
      if (idx_q < `OFS_TIME)
         cur_byte = hdr[8*(int'(`OFS_TIME) - 1 - int'(idx_q)) +: 8];
      else if (idx_q < `OFS_NMEA)
         cur_byte = tsec[8*(int'(`OFS_NMEA) - 1 - int'(idx_q)) +: 8];
      else if (idx_q < `OFS_FILL)
         cur_byte = sen_q[idx_q - `OFS_NMEA];
      else if (idx_q < `OFS_STAT)
         cur_byte = `FILL_BYTE; // see R19
      else
         cur_byte = tail[8*(int'(`FRAME_LEN) - 1 - int'(idx_q)) +: 8];
   end

   assign start = sec_tick && !ctrl_q[`CTRL_PTP] && !busy; // see R01 see R02
   assign ld    = busy && (!tx_q.valid || tx_ready);

   always_comb begin
      fs_d     = fs_q;
      idx_d    = idx_q;
      tx_d     = tx_q;
      fr_us_d  = fr_us_q;
      fr_st_d  = fr_st_q;
      fr_pps_d = fr_pps_q;
      case (fs_q)
         gps_framer_pkg::FS_IDLE: begin
            if (start) begin
               fs_d     = gps_framer_pkg::FS_SEND;
               idx_d    = 10'h000;
               fr_us_d  = us_q;
               fr_st_d  = (!gga && !nmea_lock_q) ? 8'h00 : fix_q.st; // see R11
               fr_pps_d = pps_lock_q; // see R13
            end
         end
         gps_framer_pkg::FS_SEND: begin
            if (ld && idx_q == `FRAME_LEN) begin
               tx_d = '0;
               fs_d = gps_framer_pkg::FS_IDLE;
            end else if (ld) begin
               tx_d.valid = 1'b1;
               tx_d.last  = (idx_q == `FRAME_LEN - 10'h001); // see R19
               tx_d.data  = cur_byte;
               idx_d      = idx_q + 10'h001;
            end
         end
         default: fs_d = gps_framer_pkg::FS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_q     <= gps_framer_pkg::FS_IDLE;
         idx_q    <= 10'h000;
         tx_q     <= '0;
         fr_us_q  <= 32'h0000_0000;
         fr_st_q  <= 8'h00;
         fr_pps_q <= 1'b0;
      end else begin
         fs_q     <= fs_d;
         idx_q    <= idx_d;
         tx_q     <= tx_d;
         fr_us_q  <= fr_us_d;
         fr_st_q  <= fr_st_d;
         fr_pps_q <= fr_pps_d;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_frame_start: assert property ( // see R01
      sec_tick && !ctrl_q[`CTRL_PTP] && !busy |=> busy ##1 !start)
      else $error("second tick did not start a frame");
   a_ptp_quiet: assert property ( // see R02
      ctrl_q[`CTRL_PTP] && !busy |=> !busy)
      else $error("frame started with PTP source");
   a_us_order: assert property ( // see R03
      ld && idx_q == `OFS_US |=> tx_data == fr_us_q[7:0])
      else $error("microsecond field not LSB first");
   a_src_ip: assert property ( // see R04
      ld && idx_q == `OFS_IP_SRC |=> tx_data == src_ip_q[31:24])
      else $error("source IP byte wrong");
   a_dst_ip: assert property ( // see R05
      ld && idx_q == `OFS_IP_DST |=> tx_data == 8'hff)
      else $error("destination IP byte wrong");
   a_eth_type: assert property ( // see R06
      ld && idx_q == `OFS_TYPE |=> tx_data == 8'h08 ##1 tx_valid[*1])
      else $error("ethertype byte wrong");
   a_udp_port: assert property ( // see R07
      ld && idx_q == `OFS_UDP |=> tx_data == 8'h27)
      else $error("UDP source port wrong");
   a_udp_len: assert property ( // see R08
      ld && idx_q == `OFS_UDP_LEN |=> tx_data == 8'h02)
      else $error("UDP length wrong");
   a_time_mark: assert property ( // see R09
      ld && idx_q == `OFS_TIME |=> tx_data == 8'hff)
      else $error("time marker wrong");
   a_nmea_copy: assert property ( // see R10
      ld && idx_q == `OFS_NMEA |=> tx_data == sen_q[0])
      else $error("sentence copy wrong");
   a_pps_flag: assert property ( // see R13
      ld && idx_q == `OFS_PPS |=> tx_data == {7'h00, fr_pps_q})
      else $error("PPS flag byte wrong");
   a_us_clear: assert property ( // see R16
      pps_rise |=> us_q == 32'h0000_0000)
      else $error("microsecond counter not cleared");
   a_nmea_lock: assert property ( // see R17
      sen_ok_q |=> nmea_lock_q)
      else $error("valid sentence did not lock");
   a_pps_lost: assert property ( // see R18
      wrap && wrapped_q && !pps_rise |=> !pps_lock_q)
      else $error("PPS lock kept after missed pulse");
   a_frame_len: assert property ( // see R19
      tx_valid && tx_last && tx_ready |=> !tx_valid && !busy)
      else $error("frame did not end after last byte");
   a_fill: assert property ( // see R19
      ld && idx_q == `OFS_FILL |=> tx_data == `FILL_BYTE)
      else $error("fill byte wrong");
   c_frame_done: cover property (tx_valid && tx_last && tx_ready);
   c_pps_lock: cover property (!pps_lock_q ##1 pps_lock_q);
   c_sentence: cover property (sen_ok_q && !busy);
   c_stall: cover property (tx_valid && !tx_ready [*3]);
endmodule : gps_time_packet_framer

// ### gps_rx_model.sv
// Purpose: GPS receiver model driving PPS and NMEA bytes
// Assumes: One NMEA byte per pclk cycle, PPS pulse on request
// Notes:   Idle data line shows inverse of last byte
`timescale 1ns/1ps
module gps_rx_model (
   // Clock
   input  wire logic       pclk,
   // Receiver pins
   output      logic       pps_pin,
   output      logic       nmea_valid,
   output      logic [7:0] nmea_byte
);
   // ---------------------------------------------
   // Sentence sender and PPS pulser
   // ---------------------------------------------
   initial begin
      pps_pin    = 1'b0;
      nmea_valid = 1'b0;
      nmea_byte  = 8'h00;
   end
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge pclk);
         nmea_valid <= 1'b1;
         nmea_byte  <= 8'(s[i]);
      end
      @(posedge pclk);
      nmea_valid <= 1'b0;
      nmea_byte  <= ~nmea_byte; // Stale byte must not look valid
   endtask : send
   // Ten-cycle high pulse; rising edge one edge after the call
   task automatic pulse;
      @(posedge pclk);
      pps_pin <= 1'b1;
      repeat (10) @(posedge pclk);
      pps_pin <= 1'b0;
   endtask : pulse
endmodule : gps_rx_model

// ### tb.sv
// Purpose: Self-checking bench for the time packet framer
// Assumes: SEC_US 200, so one second is 20000 cycles
// Notes:   Sink stalls every other cycle
`timescale 1ns/1ps
`include "gps_framer_regs.svh"
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        pps_pin, nmea_valid, tx_valid, tx_last, tx_ready;
   logic [7:0]  paddr, nmea_byte, tx_data;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  frm [0:553];
   logic [15:0] lastn;
   int          n, nfr, fails, samples_checked;
   logic [31:0] cs;
   string       s = {"$GPRMC,072242,A,3027.3680,N,11423.6975,E,",
                     "000.0,316.7,160617,004.1,W*67"};
   string       g = {"$GPGGA,123519,4807.038,N,01131.000,E,1,08,0.9,",
                     "545.4,M,46.9,M,,*47"};
   string       tm = "716061242270";
   gps_time_packet_framer #(.SEC_US(200), .NMEA_TMO_US(400), .PPS_TOL_US(5))
   u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pps_pin(pps_pin),
      .nmea_valid(nmea_valid), .nmea_byte(nmea_byte), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
   gps_rx_model u_gps (.pclk(pclk), .pps_pin(pps_pin),
      .nmea_valid(nmea_valid), .nmea_byte(nmea_byte));
   // ---------------------------------------------
   // Clock, sink and helpers
   // ---------------------------------------------
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      tx_ready <= ~tx_ready;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         frm[n] <= tx_data;
         n      <= tx_last ? 0 : n + 1;
         nfr    <= nfr + (tx_last ? 1 : 0);
         if (tx_last) lastn <= 16'(n);
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready === 1'b1);
      rd = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic complete_run;
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   initial begin
      repeat (95000) @(posedge pclk);
      fails++;
      complete_run();
   end
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      {pclk, presetn, psel, penable, pwrite, tx_ready} = 6'h00;
      {paddr, pwdata, n, nfr, fails, samples_checked} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `A_SRC_IP, 32'h0000_0000);
      chk(rd, `RST_SRC_IP);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({31'h0, pslverr}, 32'h0000_0001);
      u_gps.send(s);
      repeat (30000) @(posedge pclk);
      chk(nfr, 32'h0000_0001);
      chk(lastn, 16'h0229);
      for (int i = 0; i < 6; i++) chk(frm[i], 8'hff);
      chk({frm[12], frm[13]}, 16'h0800);
      chk({frm[26], frm[27], frm[28], frm[29]}, `RST_SRC_IP);
      chk({frm[30], frm[31], frm[32], frm[33]}, 32'hffff_ffff);
      chk({frm[34], frm[35], frm[36], frm[37]}, 32'h2710_277e);
      chk({frm[38], frm[39]}, 16'h0208);
      chk({frm[42], frm[43]}, 16'hffee);
      for (int i = 0; i < 12; i++) chk(frm[44 + i], 8'(tm[i]));
      for (int i = 0; i < s.len(); i++) chk(frm[60 + i], 8'(s[i]));
      for (int i = 144; i < 548; i++) chk(frm[i], 8'hdf);
      chk(frm[548], 8'h41);
      chk(frm[549], 8'h00);
      cs = 0;
      for (int i = 14; i < 34; i += 2) cs += {frm[i], frm[i + 1]};
      cs = (cs & 32'hffff) + (cs >> 16);
      chk(cs[15:0] + 16'(cs >> 16), 16'hffff);
      repeat (20000) @(posedge pclk);
      chk(nfr, 32'h0000_0002);
      apb(1'b1, `A_CTRL, 32'h0000_0003);
      // Two PPS pulses one second apart lock the timebase
      u_gps.pulse();
      repeat (19989) @(posedge pclk);
      u_gps.pulse();
      apb(1'b0, `A_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0002);
      apb(1'b0, `A_US, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      u_gps.send(s);
      apb(1'b0, `A_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0002);
      u_gps.send(g);
      apb(1'b0, `A_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      repeat (9500) @(posedge pclk);
      chk(nfr, 32'h0000_0002);
      complete_run();
   end
endmodule : tb
